// ### bsa_core.v
// Purpose: Four-digit packed decimal to 14-bit binary converter with an
//          APB register port, a slice carry capture register and a
//          status-bus driver for the carry-out bits.
// Assumes: pclk 250 MHz, presetn asynchronous active low.
// Notes:   The loop sequencer here stands in for the external microcode
//          controller: shift, test, multi-way branch into adjust.
//
// Notes on behaviour
// - Carry-force low zeroes every slice carry-in
// - Add hex 8 to low three digits detects eight-plus
// - Four-bit capture register with clear and enable
// - Capture ORed with status bus drives branch
// - Carry-outs driven onto status bus via buffer
// - Halve by down shift, subtract three flagged
// - Shifted-out bits enter binary result downward
// - Each loop starts shifting operand into result
// - Test adds 0888, carries saved as status
// - On exit result shifts up one place
// - Sixteen-bit decimal in, fourteen-bit binary out
//
// The implementer's own choices: the address map and the APB register port.
`include "bsa_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module bsa_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [3:0]  status_bus_in,
  output wire [3:0]  status_bus_out,
  output wire [3:0]  status_bus_oe_n,
  output wire [3:0]  branch_mod,
  output wire        busy
);
  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_TEST  = 2'h2;
  localparam ST_ADJ   = 2'h3;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [15:0] operand_q;
  reg  [15:0] operand_d;
  reg  [15:0] dec_q;
  reg  [15:0] dec_d;
  reg  [16:0] bin_q;
  reg  [16:0] bin_d;
  reg  [4:0]  iter_q;
  reg  [4:0]  iter_d;
  reg  [3:0]  cap_q;
  reg  [3:0]  cap_d;
  reg  [2:0]  ctrl_q;
  reg  [2:0]  ctrl_d;
  reg         done_q;
  reg         done_d;
  reg         drive_q;
  reg         drive_d;
  reg  [31:0] rdata_d;
  wire [15:0] addend_w;
  wire [3:0]  cout_w;
  wire [15:0] adj_w;
  wire        carry_force_zero_n;
  wire        lookahead_c0;
  wire        wr_w;
  wire        setup_rd_w;
  wire        start_w;
  wire        last_w;
  genvar      g;

  assign wr_w       = psel & penable & pwrite;
  assign setup_rd_w = psel & ~penable & ~pwrite;
  assign pready     = 1'b1;
  assign pslverr    = 1'b0;
  assign busy       = (state_q != ST_IDLE);
  assign start_w    = wr_w & (paddr == `BSA_OFF_CTRL) &
                      pwdata[`BSA_CTRL_START] & ~busy;
  assign last_w     = (iter_q == (`BSA_LOOP_COUNT - 5'h01));

  ////////////////////////////////////////////////////////////////////////
  // Digit adder: during the test cycle carry-force drops
  assign carry_force_zero_n = ctrl_q[`BSA_CTRL_CFZ_N] &
                              (state_q != ST_TEST);
  assign lookahead_c0 = 1'b0;
  assign addend_w = (state_q == ST_TEST) ? `BSA_TEST_CONST
                                         : 16'h0000;

  // Per digit: slice adder, carry gate and adjust-table entry
  generate
    for (g = 0; g < 4; g = g + 1) begin : gdig
      wire [4:0] sum_w;
      wire       cin_w;
      if (g == 0) begin : gfirst
        assign cin_w = lookahead_c0 & carry_force_zero_n;
      end else begin : gnext
        assign cin_w = cout_w[g-1] & carry_force_zero_n;
      end
      assign sum_w = {1'b0, dec_q[4*g +: 4]} +
                     {1'b0, addend_w[4*g +: 4]} +
                     {4'h0, cin_w};
      assign cout_w[g] = sum_w[4];
      assign adj_w[4*g +: 4] = cap_q[g] ?
                               dec_q[4*g +: 4] - `BSA_ADJ_CONST :
                               dec_q[4*g +: 4];
    end
  endgenerate

  // Status bus and branch modifier
  assign status_bus_out  = cout_w;
  assign status_bus_oe_n = {4{~drive_q}};
  assign branch_mod      = cap_q | status_bus_in;

  ////////////////////////////////////////////////////////////////////////
  // Register port: next values
  always @* begin
    operand_d = operand_q;
    if (wr_w && (paddr == `BSA_OFF_OPERAND) && !busy) begin
      operand_d = pwdata[15:0];
    end
  end

  // Clear-capture is a one-cycle pulse
  always @* begin
    ctrl_d = ctrl_q;
    ctrl_d[`BSA_CTRL_CLRCAP] = 1'b0;
    if (wr_w && (paddr == `BSA_OFF_CTRL)) begin
      ctrl_d[`BSA_CTRL_CFZ_N]  = pwdata[`BSA_CTRL_CFZ_N];
      ctrl_d[`BSA_CTRL_CLRCAP] = pwdata[`BSA_CTRL_CLRCAP];
    end
  end

  always @* begin
    drive_d = drive_q;
    if (wr_w && (paddr == `BSA_OFF_FLAGS)) begin
      drive_d = pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Loop sequencer standing in for the microprogram controller
  always @* begin
    state_d = state_q;
    dec_d   = dec_q;
    bin_d   = bin_q;
    iter_d  = iter_q;
    cap_d   = cap_q;
    done_d  = done_q;
    case (state_q)
      ST_IDLE: begin
        if (start_w) begin
          dec_d   = operand_q;
          bin_d   = 17'h00000;
          iter_d  = 5'h00;
          cap_d   = 4'h0;
          done_d  = 1'b0;
          state_d = ST_SHIFT;
        end else if (ctrl_q[`BSA_CTRL_CLRCAP]) begin
          cap_d = 4'h0;
        end
      end
      ST_SHIFT: begin
        bin_d   = {dec_q[0], bin_q[16:1]};
        dec_d   = {1'b0, dec_q[15:1]};
        state_d = ST_TEST;
      end
      ST_TEST: begin
        cap_d   = cout_w;
        state_d = ST_ADJ;
      end
      ST_ADJ: begin
        // Adjust and next halving in one cycle
        iter_d = iter_q + 5'h01;
        cap_d  = 4'h0;
        dec_d  = {1'b0, adj_w[15:1]};
        if (last_w) begin
          // Last halving and the fix-up up shift cancel out
          bin_d   = {bin_q[16:1], 1'b0};
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          bin_d   = {adj_w[0], bin_q[16:1]};
          state_d = ST_TEST;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle, shown in the access cycle
  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `BSA_OFF_OPERAND: begin
        rdata_d = {16'h0000, operand_q};
      end
      `BSA_OFF_RESULT: begin
        rdata_d = {18'h00000, bin_q[`BSA_RES_WIDTH:1]};
      end
      `BSA_OFF_CTRL: begin
        rdata_d = {29'h00000000, ctrl_q};
      end
      `BSA_OFF_STATUS: begin
        rdata_d = {30'h00000000, done_q, busy};
      end
      `BSA_OFF_FLAGS: begin
        rdata_d = {23'h000000, drive_q, cap_q, cout_w};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_q <= 16'h0000;
    end else begin
      operand_q <= operand_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q <= 16'h0000;
    end else begin
      dec_q <= dec_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bin_q <= 17'h00000;
    end else begin
      bin_q <= bin_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iter_q <= 5'h00;
    end else begin
      iter_q <= iter_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= 4'h0;
    end else begin
      cap_q <= cap_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BSA_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= drive_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd_w) begin
      prdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ### bsa_core_monitor.sv
// Purpose: Port checks for the decimal converter
// Assumes: One clock, reset active low
// Notes: Bound from the bench
`timescale 1ns/10ps
`default_nettype none
module bsa_mon (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  status_bus_in,
  input wire logic [3:0]  status_bus_oe_n,
  input wire logic [3:0]  branch_mod,
  input wire logic        busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ok = psel && penable && !pwrite;
  wire go = psel && penable && pwrite && paddr == 12'h008 && pwdata[0];
  // Shift cycle then sixteen test and adjust pairs
  sequence s_run; ##32 busy ##1 !busy; endsequence
  property p_go; go && !busy |=> busy; endproperty
  property p_len; $rose(busy) |-> s_run; endproperty
  property p_clr; $rose(busy) |-> branch_mod == status_bus_in; endproperty
  property p_br; (branch_mod & status_bus_in) == status_bus_in; endproperty
  property p_r14; rd_ok && paddr == 12'h004 |-> prdata[31:14] == 0;
  endproperty
  property p_sts; rd_ok && paddr == 12'h00C |-> prdata[0] == $past(busy);
  endproperty
  property p_oe; status_bus_oe_n == 4'h0 || status_bus_oe_n == 4'hF;
  endproperty
  property p_rdy; pready && !pslverr; endproperty
  a_go: assert property (p_go) else $error("start lost");
  a_len: assert property (p_len) else $error("bad length");
  a_clr: assert property (p_clr) else $error("stale flags");
  a_br: assert property (p_br) else $error("branch lost bit");
  a_r14: assert property (p_r14) else $error("wide result");
  a_sts: assert property (p_sts) else $error("status busy");
  a_oe: assert property (p_oe) else $error("split enable");
  a_rdy: assert property (p_rdy) else $error("bus answer");
endmodule
`default_nettype wire

// ### bsa_core_tb.sv
// Purpose: Register level bench for the converter
// Assumes: APB with a bounded wait for pready
// Notes: Results checked against decimal weights
`timescale 1ns/10ps
`default_nettype none
module bsa_core_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [3:0]  own = 4'hA;
  logic [15:0] vec [7] = '{16'h2904, 16'h9999, 16'h0000, 16'h0888,
                           16'h5555, 16'h8000, 16'h1999};
  wire  [31:0] prdata;
  wire  [3:0]  sbi, sbo, oen, bm;
  wire         pready, pslverr, busy;
  int          mismatches = 0, samples_checked = 0;
  always #2 pclk = ~pclk;
  bsa_core u_bsa_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_bus_in(sbi), .status_bus_out(sbo), .status_bus_oe_n(oen),
    .branch_mod(bm), .busy(busy));
  bsa_stat_model u_bsa_stat_model (.dut_out(sbo), .dut_oe_n(oen),
    .flags(own), .bus(sbi));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) mismatches++;
    if (k == 50) tally_and_finish();
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic conv(input logic [15:0] v);
    int k;
    apb(1, 12'h000, {16'h0, v});
    apb(1, 12'h008, 32'h3);
    rd = 0;
    for (k = 0; k < 60 && rd[1] !== 1'b1; k++) apb(0, 12'h00C, 0);
    if (k == 60) mismatches++;
    if (k == 60) tally_and_finish();
    apb(0, 12'h004, 0);
    chk("result", rd, v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10
        + v[3:0]);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h00C, 0);
    chk("status", rd, 0);
    apb(0, 12'h020, 0);
    chk("unmapped", rd, 0);
    apb(1, 12'h010, 1);
    #1 chk("oe_n", oen, 0);
    chk("branch", bm, sbo);
    apb(1, 12'h010, 0);
    #1 chk("own", bm, own);
    chk("oe_n off", oen, 4'hF);
    $display("register test done");
    foreach (vec[i]) conv(vec[i]);
    $display("conversion test done");
    tally_and_finish();
  end
endmodule
bind bsa_core bsa_mon u_bsa_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .status_bus_in(status_bus_in), .status_bus_oe_n(status_bus_oe_n),
  .branch_mod(branch_mod), .busy(busy));
`default_nettype wire

// ### bsa_defs.vh
// Purpose: Constants for the decimal-to-binary shift/adjust datapath.
// Assumes: Included by bsa_core.v only.
// Notes:   Offsets are byte addresses on the APB slave.
`ifndef BSA_DEFS_VH
`define BSA_DEFS_VH
`define BSA_OFF_OPERAND   12'h000
`define BSA_OFF_RESULT    12'h004
`define BSA_OFF_CTRL      12'h008
`define BSA_OFF_STATUS    12'h00C
`define BSA_OFF_FLAGS     12'h010
`define BSA_CTRL_START    0
`define BSA_CTRL_CFZ_N    1
`define BSA_CTRL_CLRCAP   2
`define BSA_STAT_BUSY     0
`define BSA_STAT_DONE     1
`define BSA_TEST_CONST    16'h0888
`define BSA_FIVE_CONST    4'hB
`define BSA_ADJ_CONST     4'h3
`define BSA_LOOP_COUNT    5'h10
`define BSA_RES_WIDTH     14
`define BSA_CTRL_RESET    3'h2
`endif

// ### bsa_stat_model.sv
// Purpose: Status unit on the shared status bus
// Assumes: Block drives only where its enable is low
// Notes: Own flags show wherever the block lets go
`timescale 1ns/10ps
`default_nettype none
module bsa_stat_model (
  input  wire logic [3:0] dut_out,
  input  wire logic [3:0] dut_oe_n,
  input  wire logic [3:0] flags,
  output wire logic [3:0] bus
);
  assign bus = (dut_out & ~dut_oe_n) | (flags & dut_oe_n);
endmodule
`default_nettype wire
